// file: src/rmts_pkg.sv
// Package of constants and types for the radio mode top sequencer
package rmts_pkg;
    localparam int unsigned CLK_MHZ = 200;
    // Post-reset settle before the ready clock starts
    localparam int unsigned READY_DELAY_US = 100;
    localparam int unsigned READY_CYC = READY_DELAY_US * CLK_MHZ;
    // RC oscillator tick divider
    localparam logic [7:0] RC_DIV = 8'hC7;
    localparam logic [1:0] START_TO_LPSEL = 2'h0;
    localparam logic [1:0] START_TO_RX = 2'h1;
    localparam logic [1:0] START_TO_TX = 2'h2;
    localparam logic [2:0] RXT_SEQOFF_PREAMBLE = 3'h6;
    localparam logic [2:0] RXT_SEQOFF_SYNC = 3'h5;
    localparam logic [2:0] RXT_SEQOFF_PAYLOAD = 3'h4;
    localparam logic [1:0] TMO_TO_LPSEL = 2'h2;
    localparam logic [1:0] DIO_MAP_PREAMBLE = 2'h3;
    localparam logic [1:0] DIO_MAP_SYNC = 2'h3;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    typedef enum logic [2:0] {
        RMTS_OFF, RMTS_START, RMTS_LPSEL, RMTS_IDLE, RMTS_RX, RMTS_TX,
        RMTS_HOLD_RX
    } rmts_state_t;
endpackage : rmts_pkg

// file: src/rmts_top.sv
// Radio mode top sequencer: idle, timed receive and transmit
`timescale 1ns/1ps
`default_nettype none
module rmts_top
    import rmts_pkg::*;
(
    input wire logic clk_i,                    // 200 MHz clock
    input wire logic rst_n_i,                  // Sync reset, active low
    input wire logic reset_input_n_i,          // Reset pin, active low
    input wire logic seq_start_i,              // Start pulse
    input wire logic sequencer_halt_i,         // Stop pulse
    input wire logic idle_state_select_i,      // 1 sleep, 0 standby
    input wire logic [1:0] start_transition_i, // From start
    input wire logic low_power_choice_i,       // 1 idle, 0 seq off
    input wire logic idle_transition_i,        // 1 rx, 0 tx on T1
    input wire logic [2:0] receive_transition_i, // From receive
    input wire logic [1:0] rx_timeout_transition_i, // From rx timeout
    input wire logic transmit_transition_i,    // 0 lpsel on sent
    input wire logic [15:0] first_timer_i,     // T1 in RC ticks
    input wire logic [15:0] second_timer_i,    // T2 in RC ticks
    input wire logic [15:0] receive_timeout_i, // Rx timeout, 0 off
    input wire logic beacon_enable_i,          // Beacon enable, not used by the logic
    input wire logic preamble_map_select_i,    // Preamble mapping
    input wire logic [1:0] dio2_map_i,         // Output 2 mapping
    input wire logic [1:0] digital_output_4_map_i,         // Output 4 mapping
    input wire logic preamble_detected_event_i, // Modem pulse
    input wire logic sync_match_event_i,       // Modem pulse
    input wire logic payload_complete_event_i, // Modem pulse
    input wire logic packet_sent_event_i,      // Modem pulse
    output logic ready_clock_output_o,         // Ready clock
    output logic seq_running_o,                // Sequencer active
    output logic rc_only_o,                    // Only RC osc running
    output logic rx_on_o,                      // Receiver enable
    output logic tx_on_o,                      // Transmitter enable
    output logic irq_o,                        // Packet interrupt
    output logic digital_output_2_o,           // Mapped event 2
    output logic digital_output_4_o            // Mapped event 4
);
    rmts_state_t state_r;
    logic pin_s1_r, pin_s2_r;
    logic [15:0] ready_cnt_r;
    logic ready_r;
    logic [7:0] rc_div_r;
    logic rc_tick;
    logic [15:0] t_cnt_r;
    logic [15:0] to_cnt_r;
    logic pre_seen_r;
    logic t1_done, t2_done, to_done, to_arm;
    logic dev_rst;

    // Receiver powered: timed receive or held receive
    function automatic logic rx_state(input rmts_state_t s);
        return s == RMTS_RX || s == RMTS_HOLD_RX;
    endfunction : rx_state

    // Reset pin synchroniser
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            pin_s1_r <= 1'b1;
            pin_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= reset_input_n_i;
            pin_s2_r <= pin_s1_r;
        end
    end
    assign dev_rst = !rst_n_i || !pin_s2_r;

    // Ready delay then clock output toggles
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            ready_cnt_r <= 16'h0000;
            ready_r <= 1'b0;
        end else if (ready_cnt_r == 16'(READY_CYC - 1)) begin
            ready_r <= 1'b1;
        end else begin
            ready_cnt_r <= ready_cnt_r + 16'h0001;
        end
    end
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            ready_clock_output_o <= 1'b0;
        end else if (ready_r && rc_tick) begin
            ready_clock_output_o <= !ready_clock_output_o;
        end
    end

    // RC oscillator tick emulation
    always_ff @(posedge clk_i) begin
        if (dev_rst || rc_div_r == RC_DIV) begin
            rc_div_r <= 8'h00;
        end else begin
            rc_div_r <= rc_div_r + 8'h01;
        end
    end
    assign rc_tick = (rc_div_r == RC_DIV);

    // T1 then T2 phases; T2 runs from receive/transmit entry
    assign t1_done = rc_tick && (t_cnt_r >= first_timer_i);
    assign t2_done = rc_tick && (t_cnt_r >= second_timer_i);
    assign to_arm = receive_timeout_i != 16'h0000;
    assign to_done = to_arm && rc_tick && (to_cnt_r >= receive_timeout_i);

    always_ff @(posedge clk_i) begin
        if (dev_rst || state_r == RMTS_START || state_r == RMTS_LPSEL) begin
            t_cnt_r <= TIMER_RST;
        end else if (state_r == RMTS_IDLE && t1_done) begin
            t_cnt_r <= TIMER_RST;
        end else if (rc_tick) begin
            t_cnt_r <= t_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (dev_rst || state_r != RMTS_RX) begin
            to_cnt_r <= 16'h0000;
        end else if (rc_tick) begin
            to_cnt_r <= to_cnt_r + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (dev_rst || state_r != RMTS_RX) begin
            pre_seen_r <= 1'b0;
        end else if (preamble_detected_event_i) begin
            pre_seen_r <= 1'b1;
        end
    end

    // Sequencer state machine
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            state_r <= RMTS_OFF;
        end else if (sequencer_halt_i) begin
            state_r <= RMTS_OFF;
        end else begin
            case (state_r)
                RMTS_OFF: begin
                    if (seq_start_i && ready_r) begin
                        state_r <= RMTS_START;
                    end
                end
                RMTS_START: begin
                    case (start_transition_i)
                        START_TO_LPSEL: state_r <= RMTS_LPSEL;
                        START_TO_RX: state_r <= RMTS_RX;
                        START_TO_TX: state_r <= RMTS_TX;
                        default: state_r <= RMTS_LPSEL;
                    endcase
                end
                RMTS_LPSEL: begin
                    state_r <= low_power_choice_i ? RMTS_IDLE : RMTS_OFF;
                end
                RMTS_IDLE: begin
                    if (t1_done) begin
                        state_r <= idle_transition_i ? RMTS_RX : RMTS_TX;
                    end
                end
                RMTS_RX: begin
                    if (receive_transition_i == RXT_SEQOFF_PREAMBLE &&
                        preamble_detected_event_i) begin
                        state_r <= RMTS_HOLD_RX;
                    end else if (receive_transition_i == RXT_SEQOFF_SYNC &&
                                 sync_match_event_i) begin
                        state_r <= RMTS_HOLD_RX;
                    end else if (receive_transition_i == RXT_SEQOFF_PAYLOAD &&
                                 payload_complete_event_i) begin
                        state_r <= RMTS_HOLD_RX;
                    end else if (to_done && !pre_seen_r &&
                                 rx_timeout_transition_i == TMO_TO_LPSEL) begin
                        state_r <= RMTS_LPSEL;
                    end else if (t2_done) begin
                        state_r <= RMTS_LPSEL;
                    end
                end
                RMTS_TX: begin
                    if (packet_sent_event_i && !transmit_transition_i) begin
                        state_r <= RMTS_LPSEL;
                    end
                end
                RMTS_HOLD_RX: begin
                    if (seq_start_i) begin
                        state_r <= RMTS_START;
                    end
                end
                default: state_r <= RMTS_OFF;
            endcase
        end
    end

    // Radio controls
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            rx_on_o <= 1'b0;
            tx_on_o <= 1'b0;
            rc_only_o <= 1'b0;
            seq_running_o <= 1'b0;
        end else begin
            rx_on_o <= rx_state(state_r);
            tx_on_o <= state_r == RMTS_TX;
            rc_only_o <= state_r == RMTS_IDLE && idle_state_select_i;
            seq_running_o <= state_r != RMTS_OFF && state_r != RMTS_HOLD_RX;
        end
    end

    // Interrupt and event routing
    always_ff @(posedge clk_i) begin
        if (dev_rst) begin
            irq_o <= 1'b0;
            digital_output_2_o <= 1'b0;
            digital_output_4_o <= 1'b0;
        end else begin
            irq_o <= rx_state(state_r) &&
                     payload_complete_event_i;
            digital_output_2_o <= dio2_map_i == DIO_MAP_SYNC &&
                                  sync_match_event_i;
            digital_output_4_o <= digital_output_4_map_i == DIO_MAP_PREAMBLE &&
                                  preamble_map_select_i &&
                                  preamble_detected_event_i;
        end
    end

    // Steps of the stop-and-hold and start behaviours
    sequence seq_sync_stop;
        state_r == RMTS_RX && receive_transition_i == RXT_SEQOFF_SYNC
        && sync_match_event_i && !sequencer_halt_i;
    endsequence : seq_sync_stop
    sequence seq_held_rx;
        state_r == RMTS_HOLD_RX ##1 rx_on_o && !seq_running_o;
    endsequence : seq_held_rx
    sequence seq_start_taken;
        state_r == RMTS_OFF && seq_start_i && ready_r && !sequencer_halt_i;
    endsequence : seq_start_taken
    sequence seq_start_walk;
        state_r == RMTS_START ##1 seq_running_o;
    endsequence : seq_start_walk

    AST_TX_ENDS: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        state_r == RMTS_TX && packet_sent_event_i && !transmit_transition_i
        && !sequencer_halt_i |=> state_r == RMTS_LPSEL ##1 state_r == RMTS_IDLE
        || !low_power_choice_i)
        else $error("tx did not end on sent");
    AST_PRE_HOLD: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        state_r == RMTS_RX && receive_transition_i == RXT_SEQOFF_PREAMBLE
        && preamble_detected_event_i && !sequencer_halt_i
        |=> state_r == RMTS_HOLD_RX ##1 rx_on_o)
        else $error("preamble did not hold rx");
    AST_HALT: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        sequencer_halt_i |=> state_r == RMTS_OFF ##1 !seq_running_o)
        else $error("halt ignored");
    AST_IRQ: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        rx_state(state_r) && payload_complete_event_i |=> irq_o)
        else $error("irq missing");
    AST_DIGITAL_OUTPUT_4: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        digital_output_4_o |-> $past(preamble_map_select_i))
        else $error("digital_output_4 without map select");
    AST_SYNC_HOLD: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        seq_sync_stop |=> seq_held_rx)
        else $error("sync match did not hold rx");
    AST_START: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        seq_start_taken |=> seq_start_walk)
        else $error("start not taken");
    AST_RX_TMO: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        state_r == RMTS_RX && to_done && !pre_seen_r
        && rx_timeout_transition_i == TMO_TO_LPSEL && !sequencer_halt_i
        && !preamble_detected_event_i && !sync_match_event_i
        && !payload_complete_event_i |=> state_r == RMTS_LPSEL)
        else $error("rx timeout ignored");
    AST_RC_ONLY: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        state_r == RMTS_IDLE && idle_state_select_i
        |=> rc_only_o && !rx_on_o && !tx_on_o)
        else $error("idle not rc only");
    AST_DIO2: assert property (
        @(posedge clk_i) disable iff (dev_rst)
        dio2_map_i == DIO_MAP_SYNC && sync_match_event_i
        |=> digital_output_2_o)
        else $error("sync event not mapped");
endmodule : rmts_top
`default_nettype wire

// file: test/rmts_modem_model.sv
// Modem stand-in: receive events gated by receiver, delayed packet sent
`timescale 1ns/1ps
`default_nettype none
module rmts_modem_model #(
    parameter int TX_CYC = 30
) (
    input wire logic clk_i,          // Clock
    input wire logic rx_on_i,        // Receiver enabled
    input wire logic tx_on_i,        // Transmitter enabled
    input wire logic [2:0] fire_i,   // Preamble, sync, payload requests
    output var logic pre_o = 1'b0,   // Preamble pulse
    output var logic sync_o = 1'b0,  // Sync pulse
    output var logic pay_o = 1'b0,   // Payload pulse
    output var logic sent_o = 1'b0   // Packet sent pulse
);
    int cnt_r = 0;
    always @(posedge clk_i) begin
        // Receive events only exist while the receiver listens
        pre_o <= fire_i[0] & rx_on_i;
        sync_o <= fire_i[1] & rx_on_i;
        pay_o <= fire_i[2] & rx_on_i;
        cnt_r <= tx_on_i ? cnt_r + 1 : 0;
        sent_o <= tx_on_i && cnt_r == TX_CYC;
    end
endmodule : rmts_modem_model
`default_nettype wire

// file: test/tb.sv
// Self-checking bench for the radio mode top sequencer
`timescale 1ns/1ps
`default_nettype none
module tb
    import rmts_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, halt = 1'b0;
    logic idle_tr = 1'b1, tx_tr = 1'b0, pmap = 1'b1, bcn = 1'b0;
    logic [2:0] rx_tr = 3'h6, fire = 3'h0;
    logic [1:0] tmo_tr = 2'h2, m2 = 2'h3, m4 = 2'h3;
    logic [15:0] t1 = 16'h0002, t2 = 16'h0002, rto = 16'h0000;
    logic [1:0] st_tr = START_TO_LPSEL;
    logic pin_n = 1'b1;
    logic pre, syn, pay, sent, rck, run, rco, rx, tx, irq, d2, d4;
    int failures = 0, compares = 0, n;
    initial forever #2.5 clk = ~clk;
    rmts_top rmts_top_inst (.clk_i(clk), .rst_n_i(rst_n),
        .reset_input_n_i(pin_n), .seq_start_i(start),
        .sequencer_halt_i(halt), .idle_state_select_i(1'b1),
        .start_transition_i(st_tr), .low_power_choice_i(1'b1),
        .idle_transition_i(idle_tr), .receive_transition_i(rx_tr),
        .rx_timeout_transition_i(tmo_tr), .transmit_transition_i(tx_tr),
        .first_timer_i(t1), .second_timer_i(t2), .receive_timeout_i(rto),
        .beacon_enable_i(bcn), .preamble_map_select_i(pmap),
        .dio2_map_i(m2), .digital_output_4_map_i(m4), .preamble_detected_event_i(pre),
        .sync_match_event_i(syn), .payload_complete_event_i(pay),
        .packet_sent_event_i(sent), .ready_clock_output_o(rck),
        .seq_running_o(run), .rc_only_o(rco), .rx_on_o(rx), .tx_on_o(tx),
        .irq_o(irq), .digital_output_2_o(d2), .digital_output_4_o(d4));
    rmts_modem_model rmts_modem_model_inst (.clk_i(clk), .rx_on_i(rx),
        .tx_on_i(tx), .fire_i(fire), .pre_o(pre), .sync_o(syn),
        .pay_o(pay), .sent_o(sent));
    task automatic print_verdict();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic mon(input int s);
        case (s)
            0: return rx;
            1: return tx;
            2: return run;
            3: return irq;
            4: return d2;
            5: return d4;
            default: return rck;
        endcase
    endfunction : mon
    // Cycles a receive or wake period may take, in clocks
    function automatic int span(input int ticks);
        return (ticks + 1) * 200 + 8;
    endfunction : span
    task automatic wait_lvl(input int s, input logic lvl, input int lim);
        for (int i = 0; i < lim; i++) begin
            @(posedge clk);
            #1;
            if (mon(s) === lvl) return;
        end
        failures++;
        print_verdict();
    endtask : wait_lvl
    task automatic pulse_start(input logic h);
        @(posedge clk);
        if (h) halt <= 1'b1;
        else start <= 1'b1;
        @(posedge clk);
        {halt, start} <= 2'h0;
    endtask : pulse_start
    task automatic fire_ev(input logic [2:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 3'h0;
    endtask : fire_ev
    task automatic rx_len();
        n = 0;
        while (rx === 1'b1 && n < 40000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 40000) begin
            failures++;
            print_verdict();
        end
    endtask : rx_len
    initial begin
        void'($urandom(39249));
        t1 <= 16'($urandom_range(1, 3));
        t2 <= 16'($urandom_range(2, 4));
        repeat (11) @(posedge clk);
        #1;
        chk({rck, run, rx, tx, irq}, 32'h0);
        @(posedge clk);
        rst_n <= 1'b1;
        wait_lvl(6, 1'b1, READY_CYC + 600);
        pulse_start(1'b0);
        wait_lvl(2, 1'b1, 8);
        repeat (2) @(posedge clk);
        #1;
        chk(rco, 1'b1);
        wait_lvl(0, 1'b1, span(t1 + t2 + 1));
        rx_len();
        chk(n > (t2 - 1) * 200 && n <= span(t2), 1'b1);
        wait_lvl(0, 1'b1, span(t1 + 2));
        fire_ev(3'h1);
        wait_lvl(5, 1'b1, 4);
        wait_lvl(2, 1'b0, 6);
        repeat (span(t2 + 2)) @(posedge clk);
        #1;
        chk(rx, 1'b1);
        pulse_start(1'b1);
        {rx_tr, rto, t1, t2} <= {RXT_SEQOFF_SYNC, 16'h0002, 16'h0040,
            16'h0006};
        pulse_start(1'b0);
        wait_lvl(0, 1'b1, span(75));
        rx_len();
        chk(n <= span(2), 1'b1);
        wait_lvl(0, 1'b1, span(72));
        fire_ev(3'h1);
        repeat (700) @(posedge clk);
        #1;
        chk(rx, 1'b1);
        rx_len();
        chk(n <= span(6), 1'b1);
        wait_lvl(0, 1'b1, span(72));
        fire_ev(3'h1);
        fire_ev(3'h2);
        wait_lvl(4, 1'b1, 4);
        wait_lvl(2, 1'b0, 6);
        fire_ev(3'h4);
        wait_lvl(3, 1'b1, 4);
        chk(rx, 1'b1);
        pulse_start(1'b1);
        {idle_tr, tx_tr, bcn, t1, t2} <= {3'h1, 16'h0002, 16'h0002};
        pulse_start(1'b0);
        for (int k = 0; k < 2; k++) begin
            wait_lvl(1, 1'b1, span(6));
            wait_lvl(1, 1'b0, 40);
        end
        pulse_start(1'b1);
        wait_lvl(2, 1'b0, 6);
        repeat (span(6)) @(posedge clk);
        #1;
        chk(tx, 1'b0);
        @(posedge clk);
        pin_n <= 1'b0;
        repeat (20) @(posedge clk);
        #1;
        chk({rck, run, rx, tx, irq}, 32'h0);
        @(posedge clk);
        pin_n <= 1'b1;
        repeat (4) @(posedge clk);
        pulse_start(1'b0);
        repeat (4) @(posedge clk);
        #1;
        chk(run, 1'b0);
        wait_lvl(6, 1'b1, READY_CYC + 600);
        @(posedge clk);
        {st_tr, rx_tr} <= {START_TO_RX, RXT_SEQOFF_PAYLOAD};
        pulse_start(1'b0);
        wait_lvl(0, 1'b1, 6);
        fire_ev(3'h4);
        wait_lvl(3, 1'b1, 4);
        wait_lvl(2, 1'b0, 6);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
